//--- logic/usw_pkg.sv
// Constants shared by the two-wire serial unit
// How it works
// - Two-wire mode follows bus protocol, with no slew limiting or input filtering.
// - Master always makes the clock; only the slave holds it; shifting is automatic.
// - The slave may insert wait states by holding SCL low.
// - The start detector sees a start condition and sets the start flag.
// - After a start, the first falling SCL edge makes the unit hold SCL low.
// - SDA is sampled on each rising SCL edge and shifted into the register.
// - After eight bits the counter overflows; SCL is held low only in MODE_TWO_HOLD.
// - Read/write bit one means the slave drives SDA, otherwise the master does.
// - After the acknowledge cycle the slave may keep holding SCL low.
// - Bytes continue in one direction until a stop or a repeated start.
// - The start detector looks at a delayed SDA, between 50 and 300 ns.
// - The start edge is caught without the system clock; the delay check and start flag need it.
// - With the external pin clock the counter counts both edges.
// - The counter can be stepped by timer overflow to form a 12-bit counter.
// - Overflow flag sets when the counter wraps from 15 to 0.
// - Clearing the start flag releases the start hold on SCL.
// - Clearing the overflow flag releases the overflow hold on SCL.
package usw_pkg;
  localparam logic [1:0]  MODE_OFF        = 2'h0;
  localparam logic [1:0]  MODE_THREE_WIRE = 2'h1;
  localparam logic [1:0]  MODE_TWO_WIRE   = 2'h2;
  localparam logic [1:0]  MODE_TWO_HOLD   = 2'h3;
  localparam logic [3:0]  COUNT_ZERO      = 4'h0;
  localparam logic [3:0]  COUNT_MAX       = 4'hf;
  localparam logic [3:0]  COUNT_STEP      = 4'h1;
  localparam logic [7:0]  DATA_RESET      = 8'hff;
  localparam int          DATA_MSB        = 7;
  localparam int          CLK_PERIOD_PS   = 8000;
  localparam int          SDA_DELAY_MIN_NS = 50;
  localparam int          SDA_DELAY_MAX_NS = 300;
  localparam int          SDA_DELAY_MIN_CYC = (SDA_DELAY_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          SDA_DELAY_MAX_CYC = (SDA_DELAY_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [5:0]  SDA_DELAY_CYC   = 6'(SDA_DELAY_MIN_CYC);
  localparam logic [5:0]  DELAY_ZERO      = 6'h0;
  localparam logic [5:0]  DELAY_STEP      = 6'h1;
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_QUALIFY = 2'b01,
    ST_FLAGGED = 2'b10
  } usw_start_state_type;
endpackage : usw_pkg

//--- logic/usw_link_edges.sv
// Link-side edge capture and clockless start detector
`timescale 1ns/10ps
`default_nettype none
module usw_link_edges (
  input  wire logic scl_clk,
  input  wire logic sda_in,
  input  wire logic reset,
  output var  logic rise_toggle,
  output var  logic rise_bit,
  output var  logic fall_toggle,
  output var  logic start_toggle
);
  // Rising SCL: take SDA and flag the edge
  always_ff @(posedge scl_clk or posedge reset) begin
    if (reset) begin
      rise_toggle <= 1'b0;
      rise_bit    <= 1'b1;
    end else begin
      rise_toggle <= ~rise_toggle;
      rise_bit    <= sda_in;
    end
  end

  // Falling SCL: flag the edge
  always_ff @(negedge scl_clk or posedge reset) begin
    if (reset) begin
      fall_toggle <= 1'b0;
    end else begin
      fall_toggle <= ~fall_toggle;
    end
  end

  // Falling SDA while SCL high is a start; clocked by SDA itself
  always_ff @(negedge sda_in or posedge reset) begin
    if (reset) begin
      start_toggle <= 1'b0;
    end else if (scl_clk) begin
      start_toggle <= ~start_toggle;
    end
  end
endmodule // usw_link_edges
`default_nettype wire

//--- logic/usw_two_wire_unit.sv
// Serial shift unit: shift register, edge counter, start and overflow SCL hold
`timescale 1ns/10ps
`default_nettype none
module usw_two_wire_unit (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       scl_clk,
  output var  logic       scl_out,
  output var  logic       scl_oe,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  output var  logic       serial_data_out,
  input  wire logic       wire_mode_bit0,
  input  wire logic       wire_mode_bit1,
  input  wire logic       clock_source_external_select,
  input  wire logic       clock_edge_select,
  input  wire logic       clock_source_timer_select,
  input  wire logic       software_clock_strobe,
  input  wire logic       timer_overflow_pulse,
  input  wire logic       data_out_enable,
  input  wire logic       port_out_bit,
  input  wire logic       data_write,
  input  wire logic [7:0] data_wdata,
  input  wire logic       counter_write,
  input  wire logic [3:0] counter_wdata,
  input  wire logic       start_flag_clear,
  input  wire logic       overflow_flag_clear,
  output var  logic [7:0] serial_shift_data_reg,
  output var  logic [3:0] counter_value,
  output var  logic       start_condition_flag,
  output var  logic       counter_overflow_flag
);
  logic                        rise_toggle;
  logic                        rise_bit;
  logic                        fall_toggle;
  logic                        start_toggle;
  logic [2:0]                  rise_sync_reg;
  logic [2:0]                  fall_sync_reg;
  logic [2:0]                  start_sync_reg;
  logic [1:0]                  sda_sync_reg;
  logic [1:0]                  scl_sync_reg;
  logic [7:0]                  shift_reg;
  logic [7:0]                  shift_next;
  logic [3:0]                  count_reg;
  logic [3:0]                  count_next;
  logic                        out_latch_reg;
  logic                        start_flag_reg;
  logic                        ovf_flag_reg;
  logic                        start_hold_reg;
  logic                        ovf_hold_reg;
  logic                        scl_oe_reg;
  logic                        sda_oe_reg;
  logic                        do_reg;
  logic [5:0]                  delay_reg;
  logic [5:0]                  delay_next;
  usw_pkg::usw_start_state_type start_state_reg;
  usw_pkg::usw_start_state_type start_state_next;

  usw_link_edges link_edges (
    .scl_clk      (scl_clk),
    .sda_in       (sda_in),
    .reset        (reset),
    .rise_toggle  (rise_toggle),
    .rise_bit     (rise_bit),
    .fall_toggle  (fall_toggle),
    .start_toggle (start_toggle)
  );

  // Toggle crossings and pin level synchronisers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rise_sync_reg  <= 3'h0;
      fall_sync_reg  <= 3'h0;
      start_sync_reg <= 3'h0;
      sda_sync_reg   <= 2'h3;
      scl_sync_reg   <= 2'h3;
    end else begin
      rise_sync_reg  <= {rise_sync_reg[1:0], rise_toggle};
      fall_sync_reg  <= {fall_sync_reg[1:0], fall_toggle};
      start_sync_reg <= {start_sync_reg[1:0], start_toggle};
      sda_sync_reg   <= {sda_sync_reg[0], sda_in};
      scl_sync_reg   <= {scl_sync_reg[0], scl_clk};
    end
  end

  wire two_wire      = wire_mode_bit1;
  wire ovf_hold_mode = wire_mode_bit1 & wire_mode_bit0;
  wire three_wire    = ~wire_mode_bit1 & wire_mode_bit0;
  wire sda_level     = sda_sync_reg[1];
  wire scl_level     = scl_sync_reg[1];
  wire rise_event    = rise_sync_reg[2] ^ rise_sync_reg[1];
  wire fall_event    = fall_sync_reg[2] ^ fall_sync_reg[1];
  wire start_event   = start_sync_reg[2] ^ start_sync_reg[1];

  // Edge that samples data and edge that changes the output
  wire sample_edge   = clock_edge_select ? fall_event : rise_event;
  wire change_edge   = clock_edge_select ? rise_event : fall_event;
  wire ext_edge      = rise_event | fall_event;
  wire int_tick      = clock_source_timer_select ? timer_overflow_pulse : software_clock_strobe;
  wire shift_tick    = clock_source_external_select ? sample_edge : int_tick;
  wire count_tick    = clock_source_external_select ? ext_edge : int_tick;
  wire sample_bit    = clock_source_external_select ? rise_bit : sda_level;
  wire wrap          = count_tick & (count_reg == usw_pkg::COUNT_MAX) & ~counter_write;

  // A software write wins over a shift in the same cycle
  always_comb begin
    shift_next = shift_reg;
    if (data_write) begin
      shift_next = data_wdata;
    end else if (shift_tick) begin
      shift_next = {shift_reg[6:0], sample_bit};
    end
  end

  always_comb begin
    count_next = count_reg;
    if (counter_write) begin
      count_next = counter_wdata;
    end else if (count_tick) begin
      count_next = count_reg + usw_pkg::COUNT_STEP;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_reg <= usw_pkg::DATA_RESET;
      count_reg <= usw_pkg::COUNT_ZERO;
    end else begin
      shift_reg <= shift_next;
      count_reg <= count_next;
    end
  end

  // Output latch: open on the change edge, always open on internal clock
  wire latch_open = ~clock_source_external_select | change_edge | data_write;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_latch_reg <= 1'b1;
    end else if (latch_open) begin
      out_latch_reg <= shift_next[usw_pkg::DATA_MSB];
    end
  end

  // Start qualifier: SDA must stay low for the delay while SCL holds high
  always_comb begin
    start_state_next = start_state_reg;
    delay_next       = delay_reg;
    unique case (start_state_reg)
      usw_pkg::ST_IDLE: begin
        delay_next = usw_pkg::DELAY_ZERO;
        if (start_event & two_wire) begin
          start_state_next = usw_pkg::ST_QUALIFY;
        end
      end
      usw_pkg::ST_QUALIFY: begin
        delay_next = delay_reg + usw_pkg::DELAY_STEP;
        if (sda_level | ~scl_level) begin
          start_state_next = usw_pkg::ST_IDLE;
        end else if (delay_reg == usw_pkg::SDA_DELAY_CYC) begin
          start_state_next = usw_pkg::ST_FLAGGED;
        end
      end
      usw_pkg::ST_FLAGGED: begin
        start_state_next = usw_pkg::ST_IDLE;
      end
      default: begin
        start_state_next = usw_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      start_state_reg <= usw_pkg::ST_IDLE;
      delay_reg       <= usw_pkg::DELAY_ZERO;
    end else begin
      start_state_reg <= start_state_next;
      delay_reg       <= delay_next;
    end
  end

  wire start_set = start_state_reg == usw_pkg::ST_FLAGGED;
  wire ovf_set   = wrap;

  // Flags: a set in the same cycle as a clear wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      start_flag_reg <= 1'b0;
      ovf_flag_reg   <= 1'b0;
    end else begin
      start_flag_reg <= start_set | (start_flag_reg & ~start_flag_clear);
      ovf_flag_reg   <= ovf_set | (ovf_flag_reg & ~overflow_flag_clear);
    end
  end

  // Holds: start hold arms on the first falling SCL after a start
  wire start_hold_set = two_wire & start_flag_reg & fall_event;
  wire ovf_hold_set   = ovf_hold_mode & ovf_set;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      start_hold_reg <= 1'b0;
      ovf_hold_reg   <= 1'b0;
    end else begin
      start_hold_reg <= start_hold_set | (start_hold_reg & ~start_flag_clear & two_wire);
      ovf_hold_reg   <= ovf_hold_set | (ovf_hold_reg & ~overflow_flag_clear & ovf_hold_mode);
    end
  end

  // Wait states and data drive, open-drain: enable only to pull low
  wire scl_hold_any = (start_hold_set | start_hold_reg | ovf_hold_set | ovf_hold_reg) & two_wire;
  wire sda_pull     = two_wire & data_out_enable & (~out_latch_reg | ~port_out_bit);
  wire do_level     = three_wire & out_latch_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      do_reg     <= 1'b0;
    end else begin
      scl_oe_reg <= scl_hold_any;
      sda_oe_reg <= sda_pull;
      do_reg     <= do_level;
    end
  end

  // The driven level of both open-drain lines is always low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  assign scl_oe                = scl_oe_reg;
  assign sda_oe                = sda_oe_reg;
  assign serial_data_out       = do_reg;
  assign serial_shift_data_reg = shift_reg;
  assign counter_value         = count_reg;
  assign start_condition_flag  = start_flag_reg;
  assign counter_overflow_flag = ovf_flag_reg;
endmodule // usw_two_wire_unit
`default_nettype wire

//--- verification/usw_two_wire_unit_chk.sv
// Assertion checker for the two-wire serial unit
`timescale 1ns/10ps
`default_nettype none
module usw_two_wire_unit_chk (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_oe,
  input wire logic       wire_mode_bit0,
  input wire logic       wire_mode_bit1,
  input wire logic       data_out_enable,
  input wire logic       counter_write,
  input wire logic [3:0] counter_wdata,
  input wire logic       start_flag_clear,
  input wire logic       overflow_flag_clear,
  input wire logic [3:0] counter_value,
  input wire logic       start_condition_flag,
  input wire logic       counter_overflow_flag
);
  wire logic hold_mode;
  assign hold_mode = wire_mode_bit1 & wire_mode_bit0;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Counter steps from its top value to zero
  sequence s_wrap;
    $past(counter_value) == 4'hf ##0 counter_value == 4'h0;
  endsequence
  a_wrap_sets_flag: assert property ($rose(counter_overflow_flag) |-> s_wrap)
    else $error("overflow flag set without a wrap");
  a_overflow_hold: assert property ($rose(counter_overflow_flag) && hold_mode |=> scl_oe)
    else $error("no clock hold after overflow");
  a_hold_cause: assert property (scl_oe |-> start_condition_flag || counter_overflow_flag
    || $past(start_condition_flag) || $past(counter_overflow_flag))
    else $error("clock held without a pending flag");
  a_start_release: assert property ($fell(start_condition_flag) && !counter_overflow_flag |=> !scl_oe)
    else $error("start hold not released");
  a_start_clear: assert property (start_flag_clear && start_condition_flag |=> !start_condition_flag)
    else $error("start flag not cleared");
  a_overflow_clear: assert property (overflow_flag_clear && counter_overflow_flag |=> !counter_overflow_flag)
    else $error("overflow flag not cleared");
  a_count_load: assert property (counter_write |=> counter_value == $past(counter_wdata))
    else $error("counter load lost");
  a_sda_direction: assert property (sda_oe |-> $past(data_out_enable) && $past(wire_mode_bit1))
    else $error("data line driven while output disabled");
  a_scl_low_only: assert property (scl_out == 1'h0)
    else $error("clock line driven high");
endmodule // usw_two_wire_unit_chk
bind usw_two_wire_unit usw_two_wire_unit_chk usw_two_wire_unit_chk_i (
  .clk(clk),
  .reset(reset),
  .scl_out(scl_out),
  .scl_oe(scl_oe),
  .sda_oe(sda_oe),
  .wire_mode_bit0(wire_mode_bit0),
  .wire_mode_bit1(wire_mode_bit1),
  .data_out_enable(data_out_enable),
  .counter_write(counter_write),
  .counter_wdata(counter_wdata),
  .start_flag_clear(start_flag_clear),
  .overflow_flag_clear(overflow_flag_clear),
  .counter_value(counter_value),
  .start_condition_flag(start_condition_flag),
  .counter_overflow_flag(counter_overflow_flag)
);
`default_nettype wire

//--- verification/usw_bus_master.sv
// Two-wire bus master model with open-drain clock and data
`timescale 1ns/10ps
`default_nettype none
module usw_bus_master (
  input  wire logic scl_line,
  input  wire logic sda_line,
  output var  logic scl_low,
  output var  logic sda_low
);
  initial begin
    scl_low = 1'h0;
    sda_low = 1'h0;
  end
  task automatic start_cond();
    sda_low = 1'h1;
    #400;
    scl_low = 1'h1;
    #62.5;
  endtask
  // One bit, 125 ns period when not stretched; a stuck clock returns unknown
  task automatic clock_bit(input logic b, output logic seen);
    int n;
    sda_low = !b;
    #42.5;
    scl_low = 1'h0;
    n = 0;
    while (scl_line !== 1'h1 && n < 500) begin
      #10;
      n++;
    end
    if (n < 500) begin
      seen = sda_line;
    end else begin
      seen = 1'hx;
    end
    #62.5;
    scl_low = 1'h1;
    #20;
  endtask
  // Free both lines, data first while the clock is low
  task automatic bus_idle();
    sda_low = 1'h0;
    #20;
    scl_low = 1'h0;
    #100;
  endtask
endmodule // usw_bus_master
`default_nettype wire

//--- verification/usw_two_wire_unit_tb.sv
// Testbench for the two-wire serial unit
`timescale 1ns/10ps
`default_nettype none
module usw_two_wire_unit_tb;
  logic       clk = 1'h0;
  logic       reset = 1'h1;
  logic       ext_sel, tmr_sel, strobe, tmr_pulse, dir_en, dwr, cwr, sclr, oclr;
  logic [7:0] wdata, sreg, rd;
  logic [3:0] cdata, cval;
  logic       scl_oe, sda_oe, sflag, oflag, seen, m_scl_low, m_sda_low;
  logic       wm0 = 1'h1;
  logic       wm1 = 1'h1;
  logic [7:0] do_shift;
  wire logic  do_pin;
  int         fail_count = 0;
  int         compares = 0;
  wire logic  scl_clk;
  wire logic  sda_in;
  assign scl_clk = !(m_scl_low | scl_oe);
  assign sda_in = !(m_sda_low | sda_oe);
  always #4 clk = !clk;
  // Three-wire data out as the far side sees it at each rising clock
  always @(posedge scl_clk) do_shift <= {do_shift[6:0], do_pin};
  usw_bus_master m_i (.scl_line(scl_clk), .sda_line(sda_in), .scl_low(m_scl_low), .sda_low(m_sda_low));
  usw_two_wire_unit usw_two_wire_unit_i (
    .clk(clk), .reset(reset), .scl_clk(scl_clk), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe), .serial_data_out(do_pin),
    .wire_mode_bit0(wm0), .wire_mode_bit1(wm1), .clock_source_external_select(ext_sel),
    .clock_edge_select(1'h0), .clock_source_timer_select(tmr_sel), .software_clock_strobe(strobe),
    .timer_overflow_pulse(tmr_pulse), .data_out_enable(dir_en), .port_out_bit(1'h1),
    .data_write(dwr), .data_wdata(wdata), .counter_write(cwr), .counter_wdata(cdata),
    .start_flag_clear(sclr), .overflow_flag_clear(oclr), .serial_shift_data_reg(sreg),
    .counter_value(cval), .start_condition_flag(sflag), .counter_overflow_flag(oflag));
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Strobes in order: timer, software, start clear, overflow clear, counter write, data write
  task automatic pulse(input logic [5:0] p, input logic [3:0] c = 4'h0, input logic [7:0] d = 8'h00);
    @(posedge clk);
    {tmr_pulse, strobe, sclr, oclr, cwr, dwr} <= p;
    cdata <= c;
    wdata <= d;
    @(posedge clk);
    {tmr_pulse, strobe, sclr, oclr, cwr, dwr} <= 6'h00;
  endtask
  task automatic wait_oe(input logic v);
    int n;
    n = 0;
    while (scl_oe !== v && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (scl_oe !== v) begin
      fail_count++;
    end
  endtask
  task automatic byte_xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      m_i.clock_bit(tx[i], seen);
      rx[i] = seen;
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    {ext_sel, tmr_sel, strobe, tmr_pulse, dir_en, dwr, cwr, sclr, oclr} = 9'h000;
    wdata = 8'h00;
    cdata = 4'h0;
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    tmr_sel <= 1'h1;
    pulse(6'h02, 4'he);
    pulse(6'h10);
    pulse(6'h20);
    pulse(6'h20);
    repeat (3) @(posedge clk);
    check("count", cval, 8'h00);
    check("overflow", oflag, 8'h01);
    check("overflow hold", scl_oe, 8'h01);
    pulse(6'h04);
    repeat (3) @(posedge clk);
    check("overflow cleared", oflag, 8'h00);
    check("overflow released", scl_oe, 8'h00);
    wm0 <= 1'h0;
    pulse(6'h02, 4'hf);
    pulse(6'h20);
    repeat (3) @(posedge clk);
    check("plain mode overflow", oflag, 8'h01);
    check("plain mode no hold", scl_oe, 8'h00);
    pulse(6'h04);
    wm0 <= 1'h1;
    ext_sel <= 1'h1;
    tmr_sel <= 1'h0;
    m_i.start_cond();
    check("start", sflag, 8'h01);
    wait_oe(1'h1);
    check("start hold", scl_oe, 8'h01);
    pulse(6'h0a, 4'h0);
    wait_oe(1'h0);
    check("start released", scl_oe, 8'h00);
    byte_xfer(8'ha7, rd);
    wait_oe(1'h1);
    check("rx byte", sreg, 8'ha7);
    check("rx hold", scl_oe, 8'h01);
    pulse(6'h03, 4'he, 8'h00);
    @(posedge clk) dir_en <= 1'h1;
    pulse(6'h04);
    m_i.clock_bit(1'h1, seen);
    check("ack", seen, 8'h00);
    wait_oe(1'h1);
    check("ack hold", scl_oe, 8'h01);
    pulse(6'h03, 4'h0, 8'h5a);
    pulse(6'h04);
    byte_xfer(8'hff, rd);
    check("tx byte", rd, 8'h5a);
    wait_oe(1'h1);
    check("tx overflow", oflag, 8'h01);
    pulse(6'h03, 4'he, 8'hff);
    pulse(6'h04);
    m_i.clock_bit(1'h1, seen);
    check("nack", seen, 8'h01);
    wait_oe(1'h1);
    check("nack hold", scl_oe, 8'h01);
    pulse(6'h04);
    m_i.bus_idle();
    m_i.start_cond();
    check("repeated start", sflag, 8'h01);
    wait_oe(1'h1);
    check("repeated start hold", scl_oe, 8'h01);
    @(posedge clk) wm1 <= 1'h0;
    pulse(6'h0f, 4'h0, 8'h3c);
    repeat (3) @(posedge clk);
    check("three-wire release", scl_oe, 8'h00);
    check("three-wire start clear", sflag, 8'h00);
    byte_xfer(8'hc5, rd);
    repeat (6) @(posedge clk);
    check("three-wire rx", sreg, 8'hc5);
    check("three-wire tx", do_shift, 8'h3c);
    check("three-wire overflow", oflag, 8'h01);
    check("three-wire no hold", scl_oe, 8'h00);
    close_out;
  end
  initial begin
    #100000;
    fail_count++;
    close_out;
  end
endmodule // usw_two_wire_unit_tb
`default_nettype wire
